// File: logic/dbk_regs.svh
// bit positions, reset values and widths of the debug break control block
`ifndef DBK_REGS_SVH
`define DBK_REGS_SVH
// --------------------------------------------------------------------
// watch_ctrl_reg field positions
// --------------------------------------------------------------------
`define DBK_WC_ENABLE     7
`define DBK_WC_ARM        6
`define DBK_WC_TAG        5
`define DBK_WC_BRK_ENABLE 4
`define DBK_WC_A_VALUE    3
`define DBK_WC_A_CHECK    2
`define DBK_WC_B_VALUE    1
`define DBK_WC_B_CHECK    0
`define DBK_WC_RESET      8'h00
// --------------------------------------------------------------------
// bg_ctrl_status field positions
// --------------------------------------------------------------------
`define DBK_BG_PERMIT     7
`define DBK_BG_ACTIVE     6
`define DBK_BG_CLKSEL     5
`define DBK_BG_WAIT       4
`define DBK_BG_WAITFAIL   3
`define DBK_BG_DVALID     2
`define DBK_BG_RESET      8'h00
`define DBK_BKPT_RESET    16'h0000
`endif

// File: logic/dbk_pkg.sv
// types shared by the debug break control block
`default_nettype none
package dbk_pkg;
  // ------------------------------------------------------------------
  // control register fields
  // ------------------------------------------------------------------
  typedef struct packed {
    logic enable;
    logic arm;
    logic tag;
    logic brk_enable;
    logic a_value;
    logic a_check;
    logic b_value;
    logic b_check;
  } dbk_ctrl_s;
  // ------------------------------------------------------------------
  // break request toward the core
  // ------------------------------------------------------------------
  typedef struct packed {
    logic req;
    logic tag;
    logic soft_int;
  } dbk_brk_s;
  typedef enum logic [1:0] {
    DBK_IDLE,
    DBK_PEND
  } dbk_brk_e;
endpackage
`default_nettype wire

// File: logic/dbk_break_ctrl.sv
// debug break request and control register logic
`timescale 1ns/1ps
`default_nettype none
`include "dbk_regs.svh"

// Function
// - break enable lets triggers request hardware breaks
// - tag break marks opcode entering the queue
// - force break finishes instruction, enters background
// - no background permit means software interrupt
// - 8-bit status register, 16-bit match address
// - background registers reached only by serial commands
// - permit writes ignored while background active
// - four status bits read-only, never written
// - clock source select always readable and writable
// - control register writable at any time
// - bit 7 enables unit; refused while secured
// - bit 6 arms; run done or clear stops
// - bit 5 selects tag or force type
// - bit 4 gates break requests, trace continues
// - end trace breaks on qualified trigger
// - begin trace breaks when fifo fills
// - bits 2,3 qualify comparator A direction
// - bits 0,1 qualify comparator B direction
module dbk_break_ctrl
  import dbk_pkg::*;
(
  input  wire logic        CORE_CLK_I,
  input  wire logic        RESET_N_I,
  input  wire logic        CTRL_WR_I,
  input  wire logic [7:0]  CTRL_WDATA_I,
  output var  logic [7:0]  CTRL_RDATA_O,
  input  wire logic        SECURE_I,
  input  wire logic        BG_CMD_WR_I,
  input  wire logic [7:0]  BG_CMD_WDATA_I,
  output var  logic [7:0]  BG_CMD_RDATA_O,
  input  wire logic        BKPT_CMD_WR_I,
  input  wire logic [15:0] BKPT_CMD_WDATA_I,
  output var  logic [15:0] BKPT_CMD_RDATA_O,
  input  wire logic        BG_ACTIVE_I,
  input  wire logic        WAIT_STATE_I,
  input  wire logic        WAIT_FAIL_I,
  input  wire logic        DATA_VALID_I,
  input  wire logic        CMP_A_HIT_I,
  input  wire logic        CMP_B_HIT_I,
  input  wire logic        BUS_READ_I,
  output var  logic        CMP_A_QUAL_O,
  output var  logic        CMP_B_QUAL_O,
  input  wire logic        TRACE_BEGIN_I,
  input  wire logic        TRIG_MET_I,
  input  wire logic        FIFO_FULL_I,
  input  wire logic        RUN_DONE_I,
  output var  logic        ARMED_O,
  input  wire logic        QUEUE_LOAD_I,
  input  wire logic        BRK_ACK_I,
  output var  logic        BRK_REQ_O,
  output var  logic        BRK_TAG_O,
  output var  logic        BRK_SOFTINT_O,
  output var  logic        OPCODE_MARK_O
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  dbk_ctrl_s   watch_ctrl_reg;
  dbk_ctrl_s   next_watch_ctrl_reg;
  logic        background_permit;
  logic        clock_source_select;
  logic [15:0] bg_break_match;
  logic        fifo_full_d;
  dbk_brk_e    brk_state;
  dbk_brk_e    next_brk_state;
  dbk_brk_s    brk;
  dbk_brk_s    next_brk;

  // ------------------------------------------------------------------
  // control register write decode
  // ------------------------------------------------------------------
  wire logic       wr_enable   = CTRL_WDATA_I[`DBK_WC_ENABLE];
  wire logic       wr_arm      = CTRL_WDATA_I[`DBK_WC_ARM];
  // secured part never gets the enable set
  wire logic       next_enable = CTRL_WR_I ?
                     (wr_enable & ~SECURE_I) :
                     watch_ctrl_reg.enable;
  // arm only sticks with the unit enabled
  wire logic       arm_set     = CTRL_WR_I & wr_arm & next_enable;
  wire logic       arm_clr     = RUN_DONE_I |
                     (CTRL_WR_I & (~wr_arm | ~next_enable));
  // a write that arms beats a run finishing in the same cycle
  wire logic       next_arm    = arm_set |
                     (watch_ctrl_reg.arm & ~arm_clr);
  wire logic [5:0] wr_low      = CTRL_WDATA_I[5:0];

  // control register: writable in any state
  always_comb begin
    next_watch_ctrl_reg = watch_ctrl_reg;
    if (CTRL_WR_I) begin
      {next_watch_ctrl_reg.tag, next_watch_ctrl_reg.brk_enable,
       next_watch_ctrl_reg.a_value, next_watch_ctrl_reg.a_check,
       next_watch_ctrl_reg.b_value,
       next_watch_ctrl_reg.b_check} = wr_low;
    end
    next_watch_ctrl_reg.enable = next_enable;
    next_watch_ctrl_reg.arm    = next_arm;
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!RESET_N_I) begin
      watch_ctrl_reg <= dbk_ctrl_s'(`DBK_WC_RESET);
    end else begin
      watch_ctrl_reg <= next_watch_ctrl_reg;
    end
  end

  // ------------------------------------------------------------------
  // background registers, serial command side only
  // ------------------------------------------------------------------
  // these never appear on the cpu write port
  wire logic next_permit = (BG_CMD_WR_I & ~BG_ACTIVE_I) ?
                 BG_CMD_WDATA_I[`DBK_BG_PERMIT] :
                 background_permit;
  wire logic next_clksel = BG_CMD_WR_I ?
                 BG_CMD_WDATA_I[`DBK_BG_CLKSEL] :
                 clock_source_select;

  always_ff @(posedge CORE_CLK_I) begin
    if (!RESET_N_I) begin
      background_permit   <= 1'(`DBK_BG_RESET >> `DBK_BG_PERMIT);
      clock_source_select <= 1'(`DBK_BG_RESET >> `DBK_BG_CLKSEL);
      bg_break_match      <= `DBK_BKPT_RESET;
    end else begin
      background_permit   <= next_permit;
      clock_source_select <= next_clksel;
      if (BKPT_CMD_WR_I) begin
        bg_break_match <= BKPT_CMD_WDATA_I;
      end
    end
  end

  // status image: the four flags only ever mirror the core
  wire logic [7:0] bg_image = {background_permit, BG_ACTIVE_I,
                     clock_source_select, WAIT_STATE_I,
                     WAIT_FAIL_I, DATA_VALID_I, 2'b00};

  // ------------------------------------------------------------------
  // read back, registered so outputs come from flops
  // ------------------------------------------------------------------
  // control read data tracks state; serial read data lags it by one cycle
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESET_N_I) begin
      CTRL_RDATA_O     <= 8'h00;
      BG_CMD_RDATA_O   <= 8'h00;
      BKPT_CMD_RDATA_O <= 16'h0000;
      ARMED_O          <= 1'b0;
    end else begin
      CTRL_RDATA_O     <= next_watch_ctrl_reg;
      BG_CMD_RDATA_O   <= bg_image;
      BKPT_CMD_RDATA_O <= bg_break_match;
      ARMED_O          <= next_arm;
    end
  end

  // ------------------------------------------------------------------
  // comparator direction qualification
  // ------------------------------------------------------------------
  wire logic dir_a_ok = ~watch_ctrl_reg.a_check |
                 (BUS_READ_I == watch_ctrl_reg.a_value);
  wire logic dir_b_ok = ~watch_ctrl_reg.b_check |
                 (BUS_READ_I == watch_ctrl_reg.b_value);

  always_ff @(posedge CORE_CLK_I) begin
    if (!RESET_N_I) begin
      CMP_A_QUAL_O <= 1'b0;
      CMP_B_QUAL_O <= 1'b0;
    end else begin
      CMP_A_QUAL_O <= CMP_A_HIT_I & dir_a_ok;
      CMP_B_QUAL_O <= CMP_B_HIT_I & dir_b_ok;
    end
  end

  // ------------------------------------------------------------------
  // trigger to break request
  // ------------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESET_N_I) begin
      fifo_full_d <= 1'b0;
    end else begin
      fifo_full_d <= FIFO_FULL_I;
    end
  end

  // begin trace waits for the fifo to fill, end trace for the match
  wire logic fifo_fill  = FIFO_FULL_I & ~fifo_full_d;
  wire logic trig_event = TRACE_BEGIN_I ? fifo_fill :
                          TRIG_MET_I;
  wire logic run_live   = watch_ctrl_reg.enable & watch_ctrl_reg.arm;
  // trace keeps storing with break enable clear, only the break is gated
  wire logic brk_fire   = run_live & trig_event &
                          watch_ctrl_reg.brk_enable;

  // request stays up until acknowledged; fresh fire beats ack
  always_comb begin
    next_brk_state = brk_state;
    next_brk       = brk;
    unique case (brk_state)
      DBK_IDLE: begin
        if (brk_fire) begin
          next_brk_state = DBK_PEND;
          next_brk.req   = 1'b1;
          next_brk.tag   = watch_ctrl_reg.tag;
          next_brk.soft_int = ~background_permit;
        end
      end
      DBK_PEND: begin
        if (BRK_ACK_I && !brk_fire) begin
          next_brk_state = DBK_IDLE;
          next_brk.req   = 1'b0;
        end else if (BRK_ACK_I) begin
          next_brk.tag = watch_ctrl_reg.tag;
          next_brk.soft_int = ~background_permit;
        end
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!RESET_N_I) begin
      brk_state <= DBK_IDLE;
      brk       <= '0;
    end else begin
      brk_state <= next_brk_state;
      brk       <= next_brk;
    end
  end

  // core finishes instruction for force type, uses mark for tag
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESET_N_I) begin
      BRK_REQ_O     <= 1'b0;
      BRK_TAG_O     <= 1'b0;
      BRK_SOFTINT_O <= 1'b0;
      OPCODE_MARK_O <= 1'b0;
    end else begin
      BRK_REQ_O     <= next_brk.req;
      BRK_TAG_O     <= next_brk.tag;
      BRK_SOFTINT_O <= next_brk.soft_int;
      OPCODE_MARK_O <= brk.req & brk.tag & QUEUE_LOAD_I;
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RESET_N_I);

  sequence s_fire;
    brk_fire && brk_state == DBK_IDLE;
  endsequence
  sequence s_held;
    BRK_REQ_O && !BRK_ACK_I;
  endsequence

  chk_break_gate: assert property (
    !watch_ctrl_reg.brk_enable && !BRK_REQ_O && brk_state == DBK_IDLE
    |=> !BRK_REQ_O)
    else $error("break raised with break enable clear");
  chk_break_raise: assert property (
    s_fire |=> BRK_REQ_O && BRK_TAG_O == $past(watch_ctrl_reg.tag))
    else $error("break request or type missing after trigger");
  chk_break_hold: assert property (
    s_held |=> BRK_REQ_O && $stable(BRK_TAG_O))
    else $error("break request dropped before acknowledge");
  chk_softint_select: assert property (
    s_fire |=> BRK_SOFTINT_O == !$past(background_permit))
    else $error("software interrupt choice wrong");
  chk_permit_lock: assert property (
    BG_ACTIVE_I && BG_CMD_WR_I |=> $stable(background_permit))
    else $error("permit changed in background mode");
  chk_clksel_wr: assert property (
    BG_CMD_WR_I |=> clock_source_select ==
      $past(BG_CMD_WDATA_I[`DBK_BG_CLKSEL]))
    else $error("clock select write lost");
  chk_status_ro: assert property (
    ##1 BG_CMD_RDATA_O[6:2] == $past({BG_ACTIVE_I, clock_source_select,
      WAIT_STATE_I, WAIT_FAIL_I, DATA_VALID_I}))
    else $error("status image does not mirror core");
  chk_secure_en: assert property (
    SECURE_I && CTRL_WR_I && !watch_ctrl_reg.enable
    |=> !watch_ctrl_reg.enable)
    else $error("unit enabled while secured");
  chk_arm_stop: assert property (
    RUN_DONE_I && !CTRL_WR_I |=> !watch_ctrl_reg.arm && !ARMED_O)
    else $error("arm not cleared at run end");
  chk_dir_a: assert property (
    watch_ctrl_reg.a_check && CMP_A_HIT_I &&
    BUS_READ_I != watch_ctrl_reg.a_value |=> !CMP_A_QUAL_O)
    else $error("comparator A matched wrong direction");
  chk_dir_b: assert property (
    !watch_ctrl_reg.b_check && CMP_B_HIT_I |=> CMP_B_QUAL_O)
    else $error("comparator B lost unqualified match");
  chk_begin_fill: assert property (
    TRACE_BEGIN_I && !FIFO_FULL_I && !BRK_REQ_O |=> !BRK_REQ_O)
    else $error("begin trace broke before fifo full");

endmodule
`default_nettype wire

// File: test/dbk_core_model.sv
// core pipeline model that accepts break requests after a chosen delay
`timescale 1ns/1ps
`default_nettype none
module dbk_core_model (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       brk_req_i,
  input  wire logic [3:0] delay_i,
  output var  logic       brk_ack_o
);
  logic [3:0] wait_cnt;
  // ------------------------------------------------------------------
  // break acceptance
  // ------------------------------------------------------------------
  // one ack pulse after the request stood delay_i cycles; a slow core
  // only works because the request is held as a level meanwhile
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wait_cnt  <= 4'h0;
      brk_ack_o <= 1'b0;
    end else begin
      wait_cnt  <= brk_req_i ? wait_cnt + 4'h1 : 4'h0;
      brk_ack_o <= brk_req_i && (wait_cnt == delay_i);
    end
  end
endmodule
`default_nettype wire

// File: test/test_debug_break_control.sv
// self-checking bench for the debug break control block
`timescale 1ns/1ps
`default_nettype none
module test_debug_break_control;
  import dbk_pkg::*;
  logic        clk = 1'b0, rst_n = 1'b0, ctrl_wr = 1'b0, secure = 1'b0;
  logic        bg_wr = 1'b0, bk_wr = 1'b0, bg_act = 1'b0, wst = 1'b0;
  logic        wfl = 1'b0, dvl = 1'b0, hit_a = 1'b0, hit_b = 1'b0;
  logic        rd = 1'b0, trc_beg = 1'b0, trig = 1'b0, full = 1'b0;
  logic        done = 1'b0, qload = 1'b0, ack;
  logic [7:0]  ctrl_wd = 8'h00, bg_wd = 8'h00, ctrl_rd, bg_rd;
  logic [15:0] bk_wd = 16'h0000, bk_rd;
  logic        qa, qb, armed, req, tag, sint, mark;
  int          n_errors = 0, total_checks = 0;
  // ------------------------------------------------------------------
  // clock, design and core model
  // ------------------------------------------------------------------
  always #2 clk = ~clk;
  dbk_break_ctrl i_dut (.CORE_CLK_I(clk), .RESET_N_I(rst_n),
    .CTRL_WR_I(ctrl_wr), .CTRL_WDATA_I(ctrl_wd), .CTRL_RDATA_O(ctrl_rd),
    .SECURE_I(secure), .BG_CMD_WR_I(bg_wr), .BG_CMD_WDATA_I(bg_wd),
    .BG_CMD_RDATA_O(bg_rd), .BKPT_CMD_WR_I(bk_wr), .BKPT_CMD_WDATA_I(bk_wd),
    .BKPT_CMD_RDATA_O(bk_rd), .BG_ACTIVE_I(bg_act), .WAIT_STATE_I(wst),
    .WAIT_FAIL_I(wfl), .DATA_VALID_I(dvl), .CMP_A_HIT_I(hit_a),
    .CMP_B_HIT_I(hit_b), .BUS_READ_I(rd), .CMP_A_QUAL_O(qa),
    .CMP_B_QUAL_O(qb), .TRACE_BEGIN_I(trc_beg), .TRIG_MET_I(trig),
    .FIFO_FULL_I(full), .RUN_DONE_I(done), .ARMED_O(armed),
    .QUEUE_LOAD_I(qload), .BRK_ACK_I(ack), .BRK_REQ_O(req),
    .BRK_TAG_O(tag), .BRK_SOFTINT_O(sint), .OPCODE_MARK_O(mark));
  dbk_core_model i_core (.clk_i(clk), .rst_n_i(rst_n), .brk_req_i(req),
    .delay_i(4'h8), .brk_ack_o(ack));
  // ------------------------------------------------------------------
  // access tasks
  // ------------------------------------------------------------------
  task complete_run;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] want);
    total_checks++;
    if (got !== want) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask
  // k 0 control, 1 serial status, 2 serial match; strobe one cycle
  task wr(input int k, input logic [15:0] d);
    @(posedge clk);
    ctrl_wr <= (k == 0); bg_wr <= (k == 1); bk_wr <= (k == 2);
    ctrl_wd <= d[7:0]; bg_wd <= d[7:0]; bk_wd <= d;
    @(posedge clk);
    ctrl_wr <= 1'b0; bg_wr <= 1'b0; bk_wr <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask
  // one trigger event, then request, type, mark and release
  task brk(input logic tg, input logic en, input logic bm, input logic sw);
    int i;
    wr(0, {8'h00, 2'b11, tg, en, 4'h0});
    @(posedge clk);
    trc_beg <= bm; trig <= !bm; full <= bm;
    @(posedge clk);
    trig <= 1'b0; full <= 1'b0;
    i = 0;
    while (i < 8 && req !== 1'b1) begin
      @(posedge clk); #1; i++;
    end
    chk(req, en);
    if (en) begin
      chk(tag, tg);
      chk(sint, sw);
      @(posedge clk) qload <= 1'b1;
      @(posedge clk) qload <= 1'b0;
      #1;
      chk(mark, tg);
      chk(req, 1'b1);
      i = 0;
      while (i < 16 && req !== 1'b0) begin
        @(posedge clk); #1; i++;
      end
      chk(req, 1'b0);
    end
    @(posedge clk) trc_beg <= 1'b0;
    $display("break test done tag %0d en %0d begin %0d", tg, en, bm);
  endtask
  // ------------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk); #1;
    chk(ctrl_rd, 8'h00); chk(bg_rd, 8'h00);
    wr(0, 16'h00d0); chk(ctrl_rd, 8'hd0); chk(armed, 1'b1);
    @(posedge clk) secure <= 1'b1;
    wr(0, 16'h00d0); chk(ctrl_rd, 8'h10); chk(armed, 1'b0);
    @(posedge clk) secure <= 1'b0;
    wr(0, 16'h00c0);
    @(posedge clk) done <= 1'b1;
    @(posedge clk) done <= 1'b0;
    repeat (2) @(posedge clk); #1;
    chk(ctrl_rd, 8'h80); chk(armed, 1'b0);
    wr(0, 16'h0040); chk(ctrl_rd, 8'h00);
    $display("control test done");
    // every check/value/direction pair on both comparators
    for (int c = 0; c < 8; c++) begin
      wr(0, {12'h000, c[1], c[0], c[1], c[0]});
      @(posedge clk) begin hit_a <= 1'b1; hit_b <= 1'b1; rd <= c[2]; end
      @(posedge clk) begin hit_a <= 1'b0; hit_b <= 1'b0; end
      #1;
      chk(qa, !c[0] || (c[2] == c[1]));
      chk(qb, !c[0] || (c[2] == c[1]));
    end
    $display("comparator test done");
    brk(1'b0, 1'b1, 1'b0, 1'b1);
    wr(1, 16'h00ff); chk(bg_rd, 8'ha0);
    @(posedge clk) begin
      bg_act <= 1'b1; wst <= 1'b1; wfl <= 1'b1; dvl <= 1'b1;
    end
    wr(1, 16'h0000); chk(bg_rd, 8'hdc);
    @(posedge clk) begin
      bg_act <= 1'b0; wst <= 1'b0; wfl <= 1'b0; dvl <= 1'b0;
    end
    wr(1, 16'h0080); chk(bg_rd, 8'h80);
    wr(2, 16'ha55a); chk(bk_rd, 16'ha55a);
    $display("serial register test done");
    brk(1'b0, 1'b1, 1'b0, 1'b0);
    brk(1'b1, 1'b1, 1'b0, 1'b0);
    brk(1'b1, 1'b1, 1'b1, 1'b0);
    brk(1'b1, 1'b0, 1'b0, 1'b0);
    complete_run;
  end
  // hang guard well beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    complete_run;
  end
endmodule
`default_nettype wire
